// >>> src/pcr_top.sv
`timescale 1ns/100ps
module pcr_top
  import pcr_pkg::*;
(
  // Clock and power-on reset
  input wire logic clock,
  input wire logic rst,
  // Software reset from controller logic
  input wire logic sw_rst,
  // Mode strap pins
  input wire logic host_bridge_strap_pin,
  input wire logic bus_clock_strap_pin,
  // Command register enables and system error enable
  input wire logic [2:0] cmd_enables,
  input wire logic cmd_serr_en,
  // Local peripheral bus access
  input wire logic lb_req,
  input wire logic lb_we,
  input wire logic [AW-1:0] lb_addr,
  input wire logic [DW-1:0] lb_wdata,
  output logic [DW-1:0] lb_rdata_r,
  output logic lb_ack_r,
  // PCI bus access
  input wire logic pci_req,
  input wire logic pci_we,
  input wire logic [AW-1:0] pci_addr,
  input wire logic [DW-1:0] pci_wdata,
  output logic [DW-1:0] pci_rdata_r,
  output logic pci_ack_r,
  // Gated enables
  output logic bus_master_en_r,
  output logic mem_space_en_r,
  output logic io_space_en_r,
  // Controller mode outputs
  output logic is_host_r,
  output logic single_read_buffer_r,
  output logic pio_swap_select_r,
  output logic signal_pullup_off_r,
  output logic arb_rotate_r,
  output logic grant_hold_r,
  output logic retry_r,
  output logic internal_init_r,
  output logic bus_reset_output_n_r,
  // Open-drain pins, low when enabled
  output logic inta_o,
  output logic inta_oe_r,
  output logic serr_o,
  output logic serr_oe_r
);
  // ****************************************
  // Strap capture
  // ****************************************
  logic hstrap_sync;
  logic cstrap_sync;
  logic [1:0] cap_cnt_r;
  logic cap_done_r;
  logic host_bridge_strap_r;
  logic bus_clock_strap_r;
  logic is_host;

  pcr_sync u_hsync
  (
    .clock(clock),
    .rst(rst),
    .d(host_bridge_strap_pin),
    .q_r(hstrap_sync)
  );

  pcr_sync u_csync
  (
    .clock(clock),
    .rst(rst),
    .d(bus_clock_strap_pin),
    .q_r(cstrap_sync)
  );

  // Sample once the synchroniser holds post-release pin levels
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cap_cnt_r <= 2'h0;
      cap_done_r <= 1'b0;
      host_bridge_strap_r <= 1'b0;
      bus_clock_strap_r <= 1'b0;
    end
    else if (!cap_done_r)
    begin
      cap_cnt_r <= cap_cnt_r + 2'h1;
      if (cap_cnt_r == STRAP_SETTLE)
      begin
        cap_done_r <= 1'b1;
        host_bridge_strap_r <= hstrap_sync;
        bus_clock_strap_r <= cstrap_sync;
      end
    end
  end

  // Strap zero enables the host bridge
  assign is_host = !host_bridge_strap_r;

  // ****************************************
  // Access ports
  // ****************************************
  pcr_acc_if lb_if ();
  pcr_acc_if pci_if ();

  pcr_port u_lb
  (
    .clock(clock),
    .rst(rst),
    .req(lb_req),
    .we(lb_we),
    .addr(lb_addr),
    .wdata(lb_wdata),
    .rdata_r(lb_rdata_r),
    .ack_r(lb_ack_r),
    .acc(lb_if.port)
  );

  pcr_port u_pci
  (
    .clock(clock),
    .rst(rst),
    .req(pci_req),
    .we(pci_we),
    .addr(pci_addr),
    .wdata(pci_wdata),
    .rdata_r(pci_rdata_r),
    .ack_r(pci_ack_r),
    .acc(pci_if.port)
  );

  // ****************************************
  // Power state
  // ****************************************
  pcr_pstate_type pstate_r;
  logic pm_wr;
  logic [1:0] pm_field;
  logic [1:0] pm_cur;

  // PCI wins when both sides write in one cycle
  assign pm_wr = (lb_if.pm_wr || pci_if.pm_wr) && !is_host;
  assign pm_field = pci_if.pm_wr ? pci_if.wdata[PS_HI:PS_LO] : lb_if.wdata[PS_HI:PS_LO];
  assign pm_cur = (pstate_r == PS_D3) ? PWR_D3 : PWR_D0;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      pstate_r <= PS_D0;
    else if (sw_rst)
      pstate_r <= PS_D0;
    else if (pm_wr)
    begin
      // D1 and D2 fall through and hold the state
      if (pm_field == PWR_D3)
        pstate_r <= PS_D3;
      else if (pm_field == PWR_D0)
        pstate_r <= PS_D0;
    end
  end

  // Only the power state bits are live
  assign lb_if.pm_rd = is_host ? ZERO_W : {30'h0000_0000, pm_cur};
  assign pci_if.pm_rd = lb_if.pm_rd;

  // ****************************************
  // Control register
  // ****************************************
  logic lb_key_wr;
  logic pci_key_wr;
  logic init_r;
  logic inta_bit_r;
  logic arb_sel_r;
  logic pullup_r;
  logic swap_r;
  logic srb_r;
  logic bus_reset_ctrl_r;
  logic [DW-1:0] cr_value;

  assign lb_key_wr = lb_if.cr_wr && lb_if.wdata[KEY_HI:KEY_LO] == CR_KEY;
  assign pci_key_wr = pci_if.cr_wr && pci_if.wdata[KEY_HI:KEY_LO] == CR_KEY;

  // Local side bits; the PCI side cannot reach these
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      init_r <= 1'b0;
      inta_bit_r <= 1'b0;
      arb_sel_r <= 1'b0;
      pullup_r <= 1'b0;
    end
    else if (sw_rst)
    begin
      init_r <= 1'b0;
      inta_bit_r <= 1'b0;
      arb_sel_r <= 1'b0;
      pullup_r <= 1'b0;
    end
    else if (lb_key_wr)
    begin
      init_r <= lb_if.wdata[B_INIT];
      inta_bit_r <= lb_if.wdata[B_INTA];
      arb_sel_r <= lb_if.wdata[B_ARB];
      pullup_r <= lb_if.wdata[B_PUP];
    end
  end

  // Bits writable from both sides, PCI first so it wins a tie
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      srb_r <= 1'b0;
      swap_r <= 1'b0;
    end
    else if (sw_rst)
    begin
      srb_r <= 1'b0;
      swap_r <= 1'b0;
    end
    else if (pci_key_wr)
    begin
      srb_r <= pci_if.wdata[B_SRB];
      swap_r <= pci_if.wdata[B_SWAP];
    end
    else if (lb_key_wr)
    begin
      srb_r <= lb_if.wdata[B_SRB];
      swap_r <= lb_if.wdata[B_SWAP];
    end
  end

  // Bus reset bit survives software reset
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      bus_reset_ctrl_r <= 1'b0;
    else if (lb_key_wr)
      bus_reset_ctrl_r <= lb_if.wdata[B_RST];
  end

  always_comb
  begin
    cr_value = ZERO_W;
    cr_value[B_SRB] = srb_r;
    cr_value[B_SWAP] = swap_r;
    cr_value[B_PUP] = pullup_r;
    cr_value[B_ARB] = arb_sel_r;
    cr_value[B_HSTRAP] = host_bridge_strap_r;
    cr_value[B_CSTRAP] = bus_clock_strap_r;
    cr_value[B_INTA] = inta_bit_r;
    cr_value[B_RST] = bus_reset_ctrl_r;
    cr_value[B_INIT] = init_r;
  end

  assign lb_if.cr_rd = cr_value;
  assign pci_if.cr_rd = cr_value;

  // ****************************************
  // Pin and mode outputs
  // ****************************************
  // Error strobe is a single-cycle open-drain drive
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      serr_oe_r <= 1'b0;
    else
      serr_oe_r <= !sw_rst && lb_key_wr && lb_if.wdata[B_SERR] && cmd_serr_en;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bus_master_en_r <= 1'b0;
      mem_space_en_r <= 1'b0;
      io_space_en_r <= 1'b0;
    end
    else
    begin
      bus_master_en_r <= cmd_enables[C_BM] && pstate_r == PS_D0;
      mem_space_en_r <= cmd_enables[C_MEM] && pstate_r == PS_D0;
      io_space_en_r <= cmd_enables[C_IO] && pstate_r == PS_D0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      is_host_r <= 1'b0;
      single_read_buffer_r <= 1'b0;
      pio_swap_select_r <= 1'b0;
      signal_pullup_off_r <= 1'b0;
      arb_rotate_r <= 1'b0;
      grant_hold_r <= 1'b0;
      retry_r <= 1'b0;
      internal_init_r <= 1'b0;
      bus_reset_output_n_r <= 1'b1;
      inta_oe_r <= 1'b0;
    end
    else
    begin
      is_host_r <= is_host;
      single_read_buffer_r <= srb_r;
      pio_swap_select_r <= swap_r;
      signal_pullup_off_r <= pullup_r;
      arb_rotate_r <= arb_sel_r && is_host;
      grant_hold_r <= !init_r && is_host;
      retry_r <= !init_r && !is_host;
      internal_init_r <= bus_reset_ctrl_r && is_host;
      bus_reset_output_n_r <= !(bus_reset_ctrl_r && is_host);
      inta_oe_r <= inta_bit_r && !is_host;
    end
  end

  // Open-drain pins only ever pull low
  assign inta_o = 1'b0;
  assign serr_o = 1'b0;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_pm_write(logic [1:0] v);
    pm_wr && pm_field == v && !sw_rst;
  endsequence

  sequence s_masked;
    !bus_master_en_r && !mem_space_en_r && !io_space_en_r;
  endsequence

  property p_d3_mask;
    s_pm_write(PWR_D3) |=> ##1 s_masked;
  endproperty
  a_d3_mask: assert property (p_d3_mask) else $error("D3 did not mask enables");

  property p_d0_pass;
    pstate_r == PS_D0 |=> {bus_master_en_r, mem_space_en_r, io_space_en_r} == $past(cmd_enables);
  endproperty
  a_d0_pass: assert property (p_d0_pass) else $error("D0 enables not passed");

  property p_unsup_hold;
    pm_wr && !sw_rst && (pm_field == 2'h1 || pm_field == 2'h2) |=> $stable(pstate_r);
  endproperty
  a_unsup_hold: assert property (p_unsup_hold) else $error("unsupported state moved");

  property p_pm_fixed;
    lb_if.pm_rd[DW-1:PS_HI+1] == 30'h0000_0000 && (!is_host || lb_if.pm_rd == ZERO_W);
  endproperty
  a_pm_fixed: assert property (p_pm_fixed) else $error("fixed power bits nonzero");

  property p_sw_clear;
    sw_rst |=> pm_cur == PWR_D0 && !init_r && !srb_r && !swap_r && !inta_bit_r;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("software reset left bits");

  property p_rst_kept;
    sw_rst && !lb_key_wr |=> $stable(bus_reset_ctrl_r);
  endproperty
  a_rst_kept: assert property (p_rst_kept) else $error("bus reset bit lost");

  property p_no_key;
    cap_done_r && !lb_key_wr && !pci_key_wr && !sw_rst |=> $stable(cr_value);
  endproperty
  a_no_key: assert property (p_no_key) else $error("keyless control write acted");

  property p_pci_limited;
    pci_key_wr && !lb_key_wr && !sw_rst |=>
      $stable({init_r, inta_bit_r, arb_sel_r, pullup_r, bus_reset_ctrl_r});
  endproperty
  a_pci_limited: assert property (p_pci_limited) else $error("PCI wrote local bit");

  sequence s_serr_pulse;
    serr_oe_r ##1 !serr_oe_r;
  endsequence

  property p_serr;
    lb_key_wr && lb_if.wdata[B_SERR] && cmd_serr_en && !sw_rst |=> s_serr_pulse;
  endproperty
  a_serr: assert property (p_serr) else $error("error strobe not one clock");

  property p_retry;
    !init_r && !is_host |=> retry_r && !grant_hold_r;
  endproperty
  a_retry: assert property (p_retry) else $error("retry not raised before init");

  property p_bus_reset;
    bus_reset_ctrl_r && is_host |=> !bus_reset_output_n_r && internal_init_r;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("bus reset not driven");

  property p_inta;
    ##1 inta_oe_r == $past(inta_bit_r && !is_host);
  endproperty
  a_inta: assert property (p_inta) else $error("INTA drive mismatch");

  property p_strap_hold;
    cap_done_r |=> $stable({host_bridge_strap_r, bus_clock_strap_r});
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed after capture");
endmodule

// >>> src/pcr_pkg.sv
package pcr_pkg;
  localparam int DW = 32;
  localparam int AW = 12;
  // Access offsets
  localparam logic [AW-1:0] PM_OFS = 12'h044;
  localparam logic [AW-1:0] RSV_LO = 12'h048;
  localparam logic [AW-1:0] RSV_HI = 12'h0FC;
  localparam logic [AW-1:0] CR_OFS = 12'h100;
  // Power state field
  localparam int PS_HI = 1;
  localparam int PS_LO = 0;
  localparam logic [1:0] PWR_D0 = 2'h0;
  localparam logic [1:0] PWR_D3 = 2'h3;
  // Control register fields
  localparam int KEY_HI = 31;
  localparam int KEY_LO = 24;
  localparam logic [7:0] CR_KEY = 8'hA5;
  localparam int B_SRB = 9;
  localparam int B_SWAP = 8;
  localparam int B_PUP = 7;
  localparam int B_ARB = 6;
  localparam int B_HSTRAP = 5;
  localparam int B_CSTRAP = 4;
  localparam int B_SERR = 3;
  localparam int B_INTA = 2;
  localparam int B_RST = 1;
  localparam int B_INIT = 0;
  // Command enables
  localparam int C_BM = 2;
  localparam int C_MEM = 1;
  localparam int C_IO = 0;
  localparam logic [DW-1:0] ZERO_W = 32'h0000_0000;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  typedef enum logic [1:0] {
    PS_D0 = 2'h1,
    PS_D3 = 2'h2
  } pcr_pstate_type;
endpackage

// >>> src/pcr_acc_if.sv
`timescale 1ns/100ps
interface pcr_acc_if;
  import pcr_pkg::*;
  logic pm_wr;
  logic cr_wr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] pm_rd;
  logic [DW-1:0] cr_rd;
  modport port (output pm_wr, output cr_wr, output wdata, input pm_rd, input cr_rd);
  modport core (input pm_wr, input cr_wr, input wdata, output pm_rd, output cr_rd);
endinterface

// >>> src/pcr_sync.sv
`timescale 1ns/100ps
module pcr_sync
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Level
  input wire logic d,
  output logic q_r
);
  logic meta_r;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= 1'b0;
      q_r <= 1'b0;
    end
    else
    begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end
endmodule

// >>> src/pcr_port.sv
`timescale 1ns/100ps
module pcr_port
  import pcr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Access request
  input wire logic req,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  // Answer
  output logic [DW-1:0] rdata_r,
  output logic ack_r,
  // To register core
  pcr_acc_if.port acc
);
  assign acc.pm_wr = req && we && (addr == PM_OFS);
  assign acc.cr_wr = req && we && (addr == CR_OFS);
  assign acc.wdata = wdata;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rdata_r <= ZERO_W;
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= req;
      if (req && !we)
      begin
        // Reserved window and unmapped offsets read as zero
        if (addr == PM_OFS)
          rdata_r <= acc.pm_rd;
        else if (addr == CR_OFS)
          rdata_r <= acc.cr_rd;
        else
          rdata_r <= ZERO_W;
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  property p_rsv_zero;
    req && !we && addr >= RSV_LO && addr <= RSV_HI |=> ack_r && rdata_r == ZERO_W;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved read not zero");
endmodule

// >>> tb/pcr_pci_agent.sv
`timescale 1ns/100ps
// ****************************************
// PCI side requester and pin pull-ups
// ****************************************
module pcr_pci_agent
  import pcr_pkg::*;
(
  // Clock
  input wire logic clock,
  // Register port
  output logic pci_req,
  output logic pci_we,
  output logic [AW-1:0] pci_addr,
  output logic [DW-1:0] pci_wdata,
  input wire logic [DW-1:0] pci_rdata_r,
  input wire logic pci_ack_r,
  // Open-drain pins
  input wire logic inta_o,
  input wire logic inta_oe_r,
  input wire logic serr_o,
  input wire logic serr_oe_r,
  output logic inta_line,
  output logic serr_line,
  // Answer seen at the last access
  output logic ack_seen
);
  // Released pins sit at the pull-up level
  assign inta_line = inta_oe_r ? inta_o : 1'b1;
  assign serr_line = serr_oe_r ? serr_o : 1'b1;

  initial
  begin
    pci_req = 1'b0;
    pci_we = 1'b0;
    pci_addr = 12'h000;
    pci_wdata = 32'h0000_0000;
    ack_seen = 1'b0;
  end

  // Caller supplies the key in the top byte of every control write
  task automatic access(input logic we, input logic [AW-1:0] a, input logic [DW-1:0] d,
                        output logic [DW-1:0] rd);
    @(negedge clock);
    pci_req = 1'b1;
    pci_we = we;
    pci_addr = a;
    pci_wdata = d;
    @(negedge clock);
    // Answer stands one cycle only; take it before the release
    ack_seen = pci_ack_r;
    rd = pci_rdata_r;
    // Released lines show a changed value so stale data cannot pass
    pci_req = 1'b0;
    pci_addr = ~pci_addr;
    pci_wdata = ~pci_wdata;
  endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import pcr_pkg::*;
  logic clock, rst, sw_rst, hstrap, cstrap, serr_en, lb_req, lb_we;
  logic [2:0] cmd_en;
  logic [AW-1:0] lb_addr, pci_addr;
  logic [DW-1:0] lb_wdata, lb_rdata, pci_wdata, pci_rdata, r;
  logic lb_ack, pci_req, pci_we, pci_ack, pci_seen, lb_serr;
  logic bm, mem, io, host, srb, swap, pup, arb, grant, retry, iinit, brst_n;
  logic inta_o, inta_oe, serr_o, serr_oe, inta_line, serr_line;
  logic [1:0] st;
  logic [1:0] seq [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h0};
  int mismatches = 0;
  int num_checks = 0;

  pcr_top pcr_top_inst (.clock(clock), .rst(rst), .sw_rst(sw_rst),
    .host_bridge_strap_pin(hstrap), .bus_clock_strap_pin(cstrap), .cmd_enables(cmd_en),
    .cmd_serr_en(serr_en), .lb_req(lb_req), .lb_we(lb_we), .lb_addr(lb_addr),
    .lb_wdata(lb_wdata), .lb_rdata_r(lb_rdata), .lb_ack_r(lb_ack), .pci_req(pci_req),
    .pci_we(pci_we), .pci_addr(pci_addr), .pci_wdata(pci_wdata), .pci_rdata_r(pci_rdata),
    .pci_ack_r(pci_ack), .bus_master_en_r(bm), .mem_space_en_r(mem), .io_space_en_r(io),
    .is_host_r(host), .single_read_buffer_r(srb), .pio_swap_select_r(swap),
    .signal_pullup_off_r(pup), .arb_rotate_r(arb), .grant_hold_r(grant), .retry_r(retry),
    .internal_init_r(iinit), .bus_reset_output_n_r(brst_n), .inta_o(inta_o),
    .inta_oe_r(inta_oe), .serr_o(serr_o), .serr_oe_r(serr_oe));

  pcr_pci_agent pcr_pci_agent_inst (.clock(clock), .pci_req(pci_req), .pci_we(pci_we),
    .pci_addr(pci_addr), .pci_wdata(pci_wdata), .pci_rdata_r(pci_rdata),
    .pci_ack_r(pci_ack), .inta_o(inta_o), .inta_oe_r(inta_oe), .serr_o(serr_o),
    .serr_oe_r(serr_oe), .inta_line(inta_line), .serr_line(serr_line), .ack_seen(pci_seen));

  // ****************************************
  // Clock and shared tasks
  // ****************************************
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Mode outputs packed for one compare
  function automatic logic [DW-1:0] outs();
    return {22'h0, host, srb, swap, pup, arb, grant, retry, iinit, brst_n, inta_line};
  endfunction

  task automatic acc(input logic pci, input logic we, input logic [AW-1:0] a,
                     input logic [DW-1:0] d, output logic [DW-1:0] rd);
    logic ack;
    if (pci)
    begin
      pcr_pci_agent_inst.access(we, a, d, rd);
      ack = pci_seen;
    end
    else
    begin
      @(negedge clock);
      lb_req = 1'b1;
      lb_we = we;
      lb_addr = a;
      lb_wdata = d;
      @(negedge clock);
      ack = lb_ack;
      rd = lb_rdata;
      lb_serr = !serr_line;
      lb_req = 1'b0;
      lb_addr = ~lb_addr;
      lb_wdata = ~lb_wdata;
    end
    chk({31'h0, ack}, 32'h0000_0001);
  endtask

  task automatic wr(input logic pci, input logic [AW-1:0] a, input logic [DW-1:0] d);
    acc(pci, 1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic pci, input logic [AW-1:0] a, input logic [DW-1:0] exp);
    acc(pci, 1'b0, a, 32'h0000_0000, r);
    chk(r, exp);
  endtask

  task automatic do_reset(input logic hs);
    @(negedge clock);
    rst = 1'b1;
    hstrap = hs;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (8) @(negedge clock);
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #60000;
    mismatches++;
    tally_and_finish();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    rst = 1'b1;
    sw_rst = 1'b0;
    hstrap = 1'b1;
    cstrap = 1'b1;
    cmd_en = 3'h7;
    serr_en = 1'b1;
    lb_req = 1'b0;
    lb_we = 1'b0;
    lb_addr = 12'h000;
    lb_wdata = 32'h0000_0000;
    lb_serr = 1'b0;
    do_reset(1'b1);
    rd_chk(1'b0, PM_OFS, 32'h0000_0000);
    rd_chk(1'b1, CR_OFS, 32'h0000_0030);
    chk(outs(), 32'h0000_000B);
    for (int a = 'h48; a <= 'hFC; a += 4)
      rd_chk(a[2], a[11:0], 32'h0000_0000);
    wr(1'b0, PM_OFS, 32'hFFFF_FFFF);
    rd_chk(1'b1, PM_OFS, 32'h0000_0003);
    chk({29'h0, bm, mem, io}, 32'h0000_0000);
    st = 2'h3;
    for (int i = 0; i < 7; i++)
    begin
      wr(i[0], PM_OFS, {30'h0, seq[i]});
      if (seq[i] == 2'h0 || seq[i] == 2'h3)
        st = seq[i];
      rd_chk(!i[0], PM_OFS, {30'h0, st});
      chk({29'h0, bm, mem, io}, (st == 2'h3) ? 32'h0 : 32'h7);
    end
    cmd_en = 3'h5;
    repeat (3) @(negedge clock);
    chk({29'h0, bm, mem, io}, 32'h0000_0005);
    wr(1'b0, CR_OFS, 32'h5A00_03C7);
    rd_chk(1'b0, CR_OFS, 32'h0000_0030);
    wr(1'b0, CR_OFS, 32'hA500_03C7);
    rd_chk(1'b0, CR_OFS, 32'h0000_03F7);
    chk(outs(), 32'h0000_01C2);
    wr(1'b1, CR_OFS, 32'hA500_0000);
    rd_chk(1'b1, CR_OFS, 32'h0000_00F7);
    chk(outs(), 32'h0000_0042);
    wr(1'b0, CR_OFS, 32'hA500_00CF);
    chk({31'h0, lb_serr}, 32'h0000_0001);
    @(posedge clock);
    #1;
    chk({31'h0, serr_line}, 32'h0000_0001);
    rd_chk(1'b0, CR_OFS, 32'h0000_00F7);
    @(negedge clock);
    serr_en = 1'b0;
    wr(1'b0, CR_OFS, 32'hA500_00CF);
    chk({31'h0, lb_serr}, 32'h0000_0000);
    wr(1'b1, PM_OFS, 32'h0000_0003);
    @(negedge clock);
    sw_rst = 1'b1;
    @(negedge clock);
    sw_rst = 1'b0;
    rd_chk(1'b1, PM_OFS, 32'h0000_0000);
    rd_chk(1'b0, CR_OFS, 32'h0000_0032);
    cstrap = 1'b0;
    do_reset(1'b0);
    rd_chk(1'b0, CR_OFS, 32'h0000_0000);
    chk(outs(), 32'h0000_0213);
    wr(1'b0, PM_OFS, 32'h0000_0003);
    rd_chk(1'b1, PM_OFS, 32'h0000_0000);
    chk({29'h0, bm, mem, io}, 32'h0000_0005);
    wr(1'b0, CR_OFS, 32'hA500_0047);
    rd_chk(1'b1, CR_OFS, 32'h0000_0047);
    chk(outs(), 32'h0000_0225);
    tally_and_finish();
  end
endmodule
